// file: verilog/smc_supply_monitor.sv
// supply monitor control: flags, interrupt and reset requests, trip
// selects, pad retention sequencing, and an ahb-lite register slave.
// assumes analog comparators, mode controller and regulator outside.
//
// How it works
// [R1] irq enabled, reset disabled: low supply sets flag and raises request
// [R2] writing one to the detect acknowledge clears the low-supply flag
// [R3] warning request follows the warning flag only while enabled
// [R4] writing one to the warning acknowledge clears the warning flag
// [R5] warning trip select picks one of four ordered thresholds
// [R6] retaining stop holds pads; wakeup or reset releases them at once
// [R7] retaining stop wakeup re-enables regulator, waits, then frees logic
// [R8] deep stop wakeup keeps pads held until software writes release ack
// [R9] deep stop exit through reset pin frees pads without any ack
// [R10] user-mode writes are blocked and answered with a bus error
// [R11] detection is off in any very-low-power or low-leakage mode
// [R12] detect and warning trip selects reset on power-on only, the rest on chip reset
// [R13] low-supply flag is read-only status at bit 7
// [R14] detect acknowledge is write-only and reads as zero
// [R15] detect irq enable at bit 5 requests interrupt while flag is set
// [R16] detect reset enable at bit 4 is write-once, forces chip reset
// [R17] detect register bits 3 to 2 are reserved and read zero
// [R18] detect trip select: 00 low, 01 high, 10 and 11 reserved
// [R19] software should write detect register during reset initialisation
// [R20] acknowledge clears a flag only when supply is back above trip
// [R21] after low-supply reset, chip reset holds until supply recovers
// [R22] warning select: 00 lowest, 01 first middle, 10 second middle
// [R23] comparator outputs pass a two-stage synchroniser before use
`timescale 1ns/100ps
module smc_supply_monitor (
  input wire logic SYS_CLK_I,               // 200 MHz bus clock
  input wire logic RSTN_I,                  // chip reset not deep stop
  input wire logic POR_RSTN_I,              // power-on-only reset
  input wire logic HSEL_I,                  // ahb slave select
  input wire logic [31:0] HADDR_I,          // ahb address
  input wire logic [1:0] HTRANS_I,          // ahb transfer type
  input wire logic HWRITE_I,                // ahb write
  input wire logic [2:0] HSIZE_I,           // ahb size, word only
  input wire logic [3:0] HPROT_I,           // ahb protection
  input wire logic [31:0] HWDATA_I,         // ahb write data
  input wire logic HREADY_I,                // ahb bus ready
  output logic [31:0] HRDATA_O,             // ahb read data
  output logic HREADYOUT_O,                 // ahb slave ready
  output logic HRESP_O,                     // ahb error response
  input wire logic LOW_SUPPLY_CMP_I,        // supply below detect trip
  input wire logic SUPPLY_WARN_CMP_I,       // supply below warn trip
  input wire logic LOW_POWER_MODE_I,        // very-low-power/leak mode
  input wire logic RET_STOP_ENTER_I,        // entering retaining stop
  input wire logic DEEP_STOP_ENTER_I,       // entering deep stop
  input wire logic WAKEUP_I,                // non-reset wakeup pulse
  input wire logic REG_READY_I,             // regulator in full regulation
  output logic LOW_SUPPLY_IRQ_O,            // detect interrupt request
  output logic SUPPLY_WARN_IRQ_O,           // warning interrupt request
  output logic CHIP_RESET_REQ_O,            // forced chip reset request
  output logic [1:0] LOW_SUPPLY_TRIP_SEL_O, // detect threshold select
  output logic [1:0] SUPPLY_WARN_TRIP_SEL_O,// warning threshold select
  output logic PAD_HOLD_O,                  // pads held in their state
  output logic REG_ENABLE_O,                // regulator control enabled
  output logic LOGIC_RETAIN_O               // logic kept in retention
);

  // synchronised comparator levels
  logic [1:0] cmp_sync;
  wire low_cmp = cmp_sync[0];
  wire warn_cmp = cmp_sync[1];

  // register state
  logic low_supply_flag;
  logic low_supply_irq_en;
  logic low_supply_reset_en;
  logic reset_en_written;
  logic [1:0] low_supply_trip_sel;
  logic supply_warn_flag;
  logic supply_warn_irq_en;
  logic [1:0] supply_warn_trip_sel;
  logic [7:0] regulator_ctrl;
  smc_pkg::smc_req_t req;
  logic err_second;
  smc_pkg::smc_state_t state;
  smc_pkg::smc_state_t next_state;

  // comparators come from the analog side with no clock relation
  smc_sync #(
    .WIDTH(2)
  ) u_cmp_sync (
    .clk_i(SYS_CLK_I),
    .rstn_i(RSTN_I),
    .d_i({SUPPLY_WARN_CMP_I, LOW_SUPPLY_CMP_I}), // [R23]
    .q_o(cmp_sync)
  );

  // address phase decode
  wire addr_take = HSEL_I & HREADY_I & HTRANS_I[1];
  wire [1:0] addr_idx = HADDR_I[3:2];
  wire addr_in_block = (HADDR_I[smc_pkg::SMC_ADDR_BITS-1:4] == '0)
                       & (HADDR_I[1:0] == 2'h0);
  wire addr_mapped = addr_in_block
                     & (addr_idx != 2'h3);
  wire addr_user = ~HPROT_I[smc_pkg::SMC_HPROT_PRIV_BIT];
  wire user_write = addr_take & HWRITE_I & addr_user; // [R10]

  // data phase write strobes, only for privileged mapped writes
  wire wr_ok = req.valid & req.write & ~req.user & req.mapped;
  wire wr_detect = wr_ok & (req.idx == smc_pkg::SMC_DETECT_IDX);
  wire wr_warn = wr_ok & (req.idx == smc_pkg::SMC_WARN_IDX);
  wire wr_reg = wr_ok & (req.idx == smc_pkg::SMC_REG_IDX);
  wire [7:0] wdat = HWDATA_I[7:0];

  // detection is forced off in low-power modes, whatever the enables
  wire detect_on = ~LOW_POWER_MODE_I; // [R11]
  wire low_set = detect_on & low_cmp;
  wire warn_set = detect_on & warn_cmp;

  // an ack only clears once the supply is back above its trip point,
  // and a fresh event in the same cycle wins over the clear
  wire low_ack = wr_detect & wdat[smc_pkg::SMC_ACK_BIT]; // [R2]
  wire low_clr = low_ack & ~low_cmp; // [R20]
  wire warn_ack = wr_warn & wdat[smc_pkg::SMC_ACK_BIT]; // [R4]
  wire warn_clr = warn_ack & ~warn_cmp; // [R20]
  wire next_low_flag = low_set | (low_supply_flag & ~low_clr); // [R1]
  wire next_warn_flag = warn_set | (supply_warn_flag & ~warn_clr);

  // request lines built from flags and enables
  wire next_low_irq = low_supply_irq_en & low_supply_flag; // [R15]
  wire next_warn_irq = supply_warn_irq_en & supply_warn_flag; // [R3]
  // reset stays asserted while the comparator still reads low, so the
  // chip is not released into a sagging supply; low-power modes mask only a new detection, not a flag already set
  wire next_reset_req = low_supply_reset_en
                        & (low_supply_flag | low_set); // [R16] [R21]

  // read data mux; ack bits and reserved bits read as zero
  wire [7:0] rd_detect = {low_supply_flag, 1'b0, low_supply_irq_en,
                          low_supply_reset_en, 2'h0,
                          low_supply_trip_sel}; // [R13] [R14] [R17]
  wire [7:0] rd_warn = {supply_warn_flag, 1'b0, supply_warn_irq_en,
                        3'h0, supply_warn_trip_sel};
  wire [7:0] rd_mux = (addr_idx == smc_pkg::SMC_DETECT_IDX) ? rd_detect :
                      (addr_idx == smc_pkg::SMC_WARN_IDX) ? rd_warn :
                      (addr_idx == smc_pkg::SMC_REG_IDX) ? regulator_ctrl :
                      8'h00;
  wire [7:0] rd_byte = addr_mapped ? rd_mux : 8'h00;

  // isolation release write from software
  wire iso_release_ack = wr_reg & wdat[smc_pkg::SMC_ISO_ACK_BIT]; // [R8]

  // capture the address phase; user writes go into the error answer
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      req <= '0;
    end
    else if (HREADY_I)
    begin
      req.valid <= addr_take;
      req.write <= HWRITE_I;
      req.user <= addr_user;
      req.mapped <= addr_mapped;
      req.idx <= addr_idx;
    end
  end

  // read data is registered at the address edge: zero wait states
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      HRDATA_O <= 32'h0000_0000;
    end
    else if (addr_take & ~HWRITE_I)
    begin
      HRDATA_O <= {24'h00_0000, rd_byte};
    end
  end

  // two-cycle error answer for a blocked user write
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      err_second <= 1'b0;
    end
    else if (user_write)
    begin
      HREADYOUT_O <= 1'b0; // [R10]
      HRESP_O <= 1'b1;
      err_second <= 1'b1;
    end
    else if (err_second)
    begin
      HREADYOUT_O <= 1'b1;
      err_second <= 1'b0;
    end
    else
    begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
  end

  // detect control bits: chip reset class
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      low_supply_flag <= smc_pkg::SMC_DETECT_RST[smc_pkg::SMC_FLAG_BIT];
      low_supply_irq_en <= smc_pkg::SMC_DETECT_RST[smc_pkg::SMC_IRQ_EN_BIT];
      low_supply_reset_en <=
        smc_pkg::SMC_DETECT_RST[smc_pkg::SMC_RST_EN_BIT]; // [R12]
      reset_en_written <= 1'b0;
    end
    else
    begin
      low_supply_flag <= next_low_flag;
      if (wr_detect)
      begin
        low_supply_irq_en <= wdat[smc_pkg::SMC_IRQ_EN_BIT];
      end
      // only the first write after reset lands
      if (wr_detect & ~reset_en_written)
      begin
        low_supply_reset_en <= wdat[smc_pkg::SMC_RST_EN_BIT]; // [R16]
        reset_en_written <= 1'b1;
      end
    end
  end

  // trip selects live on the power-on-only reset so that a low-supply
  // reset does not fall back to a different threshold
  always_ff @(posedge SYS_CLK_I or negedge POR_RSTN_I)
  begin
    if (!POR_RSTN_I)
    begin
      low_supply_trip_sel <= smc_pkg::SMC_DETECT_RST[1:0]; // [R12]
      supply_warn_trip_sel <= smc_pkg::SMC_WARN_RST[1:0];
    end
    else
    begin
      if (wr_detect)
      begin
        low_supply_trip_sel <= wdat[1:0]; // [R18]
      end
      if (wr_warn)
      begin
        supply_warn_trip_sel <= wdat[1:0]; // [R5] [R22]
      end
    end
  end

  // warning control bits
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      supply_warn_flag <= smc_pkg::SMC_WARN_RST[smc_pkg::SMC_FLAG_BIT];
      supply_warn_irq_en <= smc_pkg::SMC_WARN_RST[smc_pkg::SMC_IRQ_EN_BIT];
    end
    else
    begin
      supply_warn_flag <= next_warn_flag;
      if (wr_warn)
      begin
        supply_warn_irq_en <= wdat[smc_pkg::SMC_IRQ_EN_BIT];
      end
    end
  end

  // regulator register: plain storage, the ack bit is not kept
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      regulator_ctrl <= smc_pkg::SMC_REG_RST;
    end
    else if (wr_reg)
    begin
      regulator_ctrl <= wdat & ~(8'h01 << smc_pkg::SMC_ISO_ACK_BIT);
    end
  end

  // request outputs
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      LOW_SUPPLY_IRQ_O <= 1'b0;
      SUPPLY_WARN_IRQ_O <= 1'b0;
      CHIP_RESET_REQ_O <= 1'b0;
    end
    else
    begin
      LOW_SUPPLY_IRQ_O <= next_low_irq;
      SUPPLY_WARN_IRQ_O <= next_warn_irq;
      CHIP_RESET_REQ_O <= next_reset_req;
    end
  end

  // trip select outputs mirror the registers
  always_ff @(posedge SYS_CLK_I or negedge POR_RSTN_I)
  begin
    if (!POR_RSTN_I)
    begin
      LOW_SUPPLY_TRIP_SEL_O <= smc_pkg::SMC_DETECT_RST[1:0];
      SUPPLY_WARN_TRIP_SEL_O <= smc_pkg::SMC_WARN_RST[1:0];
    end
    else
    begin
      LOW_SUPPLY_TRIP_SEL_O <= low_supply_trip_sel;
      SUPPLY_WARN_TRIP_SEL_O <= supply_warn_trip_sel;
    end
  end

  // pad retention sequencer; a reset pin exit is chip reset, which
  // drops straight back to run with pads free and no ack needed
  always_comb
  begin
    next_state = state;
    case (state)
      smc_pkg::SMC_ST_RUN:
      begin
        if (DEEP_STOP_ENTER_I)
        begin
          next_state = smc_pkg::SMC_ST_DEEP_STOP;
        end
        else if (RET_STOP_ENTER_I)
        begin
          next_state = smc_pkg::SMC_ST_RET_STOP; // [R6]
        end
      end
      smc_pkg::SMC_ST_RET_STOP:
      begin
        if (WAKEUP_I)
        begin
          next_state = smc_pkg::SMC_ST_POWER_UP; // [R7]
        end
      end
      smc_pkg::SMC_ST_POWER_UP:
      begin
        if (REG_READY_I)
        begin
          next_state = smc_pkg::SMC_ST_RUN; // [R7]
        end
      end
      smc_pkg::SMC_ST_DEEP_STOP:
      begin
        if (WAKEUP_I)
        begin
          next_state = smc_pkg::SMC_ST_ISO_HOLD; // [R8]
        end
      end
      smc_pkg::SMC_ST_ISO_HOLD:
      begin
        if (iso_release_ack)
        begin
          next_state = smc_pkg::SMC_ST_RUN; // [R8]
        end
      end
      default:
      begin
        next_state = smc_pkg::SMC_ST_RUN;
      end
    endcase
  end

  // pads hold only in stop and while waiting for the release ack;
  // retention ends once the regulator reports full regulation
  wire next_hold = (next_state == smc_pkg::SMC_ST_RET_STOP)
                   | (next_state == smc_pkg::SMC_ST_DEEP_STOP)
                   | (next_state == smc_pkg::SMC_ST_ISO_HOLD); // [R6]
  wire next_reg_en = (next_state != smc_pkg::SMC_ST_RET_STOP)
                     & (next_state != smc_pkg::SMC_ST_DEEP_STOP);
  wire next_retain = (next_state == smc_pkg::SMC_ST_RET_STOP)
                     | (next_state == smc_pkg::SMC_ST_POWER_UP);

  // state and sequencer outputs; reset releases pads at once
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      state <= smc_pkg::SMC_ST_RUN; // [R9]
      PAD_HOLD_O <= 1'b0;
      REG_ENABLE_O <= 1'b1;
      LOGIC_RETAIN_O <= 1'b0;
    end
    else
    begin
      state <= next_state;
      PAD_HOLD_O <= next_hold;
      REG_ENABLE_O <= next_reg_en;
      LOGIC_RETAIN_O <= next_retain;
    end
  end

endmodule

// file: verilog/smc_pkg.sv
// package for the supply monitor control block: register map, field
// positions, reset values, state codes and the bus capture struct.
// assumes a single 200 MHz bus clock and byte-wide registers.
package smc_pkg;

  // register block base and printed offsets (not word aligned)
  localparam logic [31:0] SMC_BASE = 32'h4007d000;
  localparam logic [31:0] SMC_DETECT_OFS = 32'h4007d000;
  localparam logic [31:0] SMC_WARN_OFS = 32'h4007d001;
  localparam logic [31:0] SMC_REG_OFS = 32'h4007d002;

  // register index inside the block; byte address is four times it
  localparam logic [1:0] SMC_DETECT_IDX = 2'h0;
  localparam logic [1:0] SMC_WARN_IDX = 2'h1;
  localparam logic [1:0] SMC_REG_IDX = 2'h2;
  localparam int SMC_ADDR_BITS = 12;

  // detect/warning control/status field positions and the regulator release ack bit
  localparam int SMC_FLAG_BIT = 7;
  localparam int SMC_ACK_BIT = 6;
  localparam int SMC_IRQ_EN_BIT = 5;
  localparam int SMC_RST_EN_BIT = 4;
  localparam int SMC_SEL_LSB = 0;
  localparam int SMC_ISO_ACK_BIT = 3;

  // reset values
  localparam logic [7:0] SMC_DETECT_RST = 8'h10;
  localparam logic [7:0] SMC_WARN_RST = 8'h00;
  localparam logic [7:0] SMC_REG_RST = 8'h04;

  // trip select codes
  localparam logic [1:0] SMC_DET_LOW = 2'h0;
  localparam logic [1:0] SMC_DET_HIGH = 2'h1;
  localparam logic [1:0] SMC_WARN_LOWEST = 2'h0;
  localparam logic [1:0] SMC_WARN_MID1 = 2'h1;
  localparam logic [1:0] SMC_WARN_MID2 = 2'h2;
  localparam logic [1:0] SMC_WARN_HIGHEST = 2'h3;

  // ahb encodings
  localparam logic [1:0] SMC_HTRANS_NONSEQ = 2'h2;
  localparam int SMC_HPROT_PRIV_BIT = 1;

  // pad retention sequencer states
  typedef enum logic [2:0] {
    SMC_ST_RUN = 3'b000,
    SMC_ST_RET_STOP = 3'b001,
    SMC_ST_POWER_UP = 3'b010,
    SMC_ST_DEEP_STOP = 3'b011,
    SMC_ST_ISO_HOLD = 3'b100
  } smc_state_t;

  // captured address phase of one bus transfer
  typedef struct packed {
    logic valid;
    logic write;
    logic user;
    logic mapped;
    logic [1:0] idx;
  } smc_req_t;

endpackage

// file: verilog/smc_sync.sv
// two-stage synchroniser, one generate loop over the bits.
// assumes inputs are levels that stay long enough to be sampled.
`timescale 1ns/100ps
module smc_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i,             // bus clock
  input wire logic rstn_i,            // async reset, active low
  input wire logic [WIDTH-1:0] d_i,   // asynchronous levels
  output logic [WIDTH-1:0] q_o        // synchronised levels
);

  logic [WIDTH-1:0] meta;

  // the first stage feeds only the second stage
  for (genvar g = 0; g < WIDTH; g++)
  begin : g_bit
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
      if (!rstn_i)
      begin
        meta[g] <= 1'b0;
        q_o[g] <= 1'b0;
      end
      else
      begin
        meta[g] <= d_i[g];
        q_o[g] <= meta[g];
      end
    end
  end

endmodule

// file: tb/smc_supply_monitor_chk.sv
// checker for the supply monitor control: bus answers, read masks,
// chip reset cause and pad retention sequencing.
// assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module smc_supply_monitor_chk (
  input wire logic SYS_CLK_I,         // bus clock
  input wire logic RSTN_I,            // chip reset, active low
  input wire logic HSEL_I,            // slave select
  input wire logic [31:0] HADDR_I,    // address
  input wire logic [1:0] HTRANS_I,    // transfer type
  input wire logic HWRITE_I,          // write
  input wire logic [3:0] HPROT_I,     // protection
  input wire logic [31:0] HWDATA_I,   // write data
  input wire logic HREADY_I,          // bus ready
  input wire logic [31:0] HRDATA_O,   // read data
  input wire logic HREADYOUT_O,       // slave ready
  input wire logic HRESP_O,           // error response
  input wire logic LOW_SUPPLY_CMP_I,  // detect comparator
  input wire logic WAKEUP_I,          // wakeup pulse
  input wire logic REG_READY_I,       // regulator ready
  input wire logic CHIP_RESET_REQ_O,  // chip reset request
  input wire logic PAD_HOLD_O,        // pads held
  input wire logic REG_ENABLE_O,      // regulator enabled
  input wire logic LOGIC_RETAIN_O     // logic retained
);
  logic iso_dph;
  // transfer decode seen at the sampling edge
  wire taken = HSEL_I && HTRANS_I[1] && HREADY_I;
  wire user_wr = taken && HWRITE_I && !HPROT_I[1];
  wire det_rd = taken && !HWRITE_I && (HADDR_I[11:0] == 12'h000);
  wire iso_hit = taken && HWRITE_I && HPROT_I[1] && (HADDR_I[11:0] == 12'h008);

  // a release write lands only at the end of its data phase
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
    if (!RSTN_I)
      iso_dph <= 1'b0;
    else if (HREADY_I)
      iso_dph <= iso_hit;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);

  user_err_a: assert property (user_wr |=> !HREADYOUT_O && HRESP_O)
    else $error("user write not answered with error");
  err_shape_a: assert property (
    $rose(HRESP_O) |-> !HREADYOUT_O
    ##1 (HRESP_O && HREADYOUT_O) ##1 !HRESP_O)
    else $error("error response not two cycles");
  ok_resp_a: assert property (
    taken && (!HWRITE_I || HPROT_I[1])
    |=> HREADYOUT_O && !HRESP_O)
    else $error("privileged access not okay");
  read_mask_a: assert property (
    det_rd |=> HRDATA_O[6] == 1'b0
    && HRDATA_O[3:2] == 2'h0 && HRDATA_O[31:8] == 24'h0)
    else $error("detect read shows ack or reserved bits");
  reset_cause_a: assert property (
    $rose(CHIP_RESET_REQ_O)
    |-> $past(LOW_SUPPLY_CMP_I, 2) || $past(LOW_SUPPLY_CMP_I, 3))
    else $error("chip reset without low supply");
  ret_wake_a: assert property (
    PAD_HOLD_O && LOGIC_RETAIN_O && WAKEUP_I
    |=> !PAD_HOLD_O && REG_ENABLE_O && LOGIC_RETAIN_O)
    else $error("pads not freed on retaining wakeup");
  retain_end_a: assert property (
    $fell(LOGIC_RETAIN_O)
    |-> $past(REG_READY_I) && REG_ENABLE_O && !PAD_HOLD_O)
    else $error("retention left before regulation");
  deep_wake_a: assert property (
    PAD_HOLD_O && !REG_ENABLE_O
    && !LOGIC_RETAIN_O && WAKEUP_I |=> PAD_HOLD_O && REG_ENABLE_O)
    else $error("deep wakeup did not keep pads held");
  iso_keep_a: assert property (
    PAD_HOLD_O && REG_ENABLE_O
    && !(iso_dph && HWDATA_I[3]) |=> PAD_HOLD_O)
    else $error("pads freed without release write");

  cover property ($rose(HRESP_O));
  cover property ($fell(PAD_HOLD_O) && REG_ENABLE_O);
  cover property ($rose(CHIP_RESET_REQ_O));
endmodule

// file: tb/smc_supply_monitor_tb_top.sv
// self-checking bench for the supply monitor control block.
// assumes a single 200 MHz clock; reads are checked from a queue.
`timescale 1ns/100ps
module smc_supply_monitor_tb_top;
  logic clk, rstn, por_rstn, hsel, hwrite, hreadyout, hresp, err;
  logic lo_cmp, warn_cmp, lp_mode, ret_in, deep_in, wake, reg_rdy;
  logic lo_irq, warn_irq, rst_req, pad_hold, reg_en, retain, rd_dph;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, lo_sel, warn_sel, rv;
  logic [3:0] hprot;
  logic [31:0] exp_q[$];
  int error_cnt, samples_checked, i;

  smc_supply_monitor dut (.SYS_CLK_I(clk), .RSTN_I(rstn),
    .POR_RSTN_I(por_rstn), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HPROT_I(hprot), .HWDATA_I(hwdata), .HREADY_I(hreadyout),
    .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
    .LOW_SUPPLY_CMP_I(lo_cmp), .SUPPLY_WARN_CMP_I(warn_cmp),
    .LOW_POWER_MODE_I(lp_mode), .RET_STOP_ENTER_I(ret_in),
    .DEEP_STOP_ENTER_I(deep_in), .WAKEUP_I(wake),
    .REG_READY_I(reg_rdy), .LOW_SUPPLY_IRQ_O(lo_irq),
    .SUPPLY_WARN_IRQ_O(warn_irq), .CHIP_RESET_REQ_O(rst_req),
    .LOW_SUPPLY_TRIP_SEL_O(lo_sel), .SUPPLY_WARN_TRIP_SEL_O(warn_sel),
    .PAD_HOLD_O(pad_hold), .REG_ENABLE_O(reg_en),
    .LOGIC_RETAIN_O(retain));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_rd(input logic [31:0] got);
    report(got, exp_q.pop_front());
  endtask

  task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one single word transfer; address held until ready is sampled
  task automatic xfer(input logic w, input logic [1:0] idx,
                      input logic [7:0] d, input logic priv);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= smc_pkg::SMC_HTRANS_NONSEQ;
    haddr <= smc_pkg::SMC_BASE | {28'h0, idx, 2'h0};
    hwrite <= w;
    hprot <= {2'h0, priv, 1'b1};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    err = 1'b0;
    do
    begin
      @(posedge clk);
      if (hresp === 1'b1)
        err = 1'b1;
    end
    while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [1:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, 1'b1);
  endtask

  task automatic rd(input logic [1:0] idx, input logic [7:0] exp);
    exp_q.push_back({24'h0, exp});
    xfer(1'b0, idx, 8'h00, 1'b1);
  endtask

  // read data watcher: compares at the edge ending a read data phase
  always @(posedge clk)
  begin
    if (rd_dph && hreadyout === 1'b1)
      cmp_rd(hrdata);
    if (hreadyout === 1'b1)
      rd_dph = hsel && htrans[1] && !hwrite;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // the whole sequence needs well under a thousand cycles
  initial
  begin
    cyc(20000);
    error_cnt++;
    complete_run();
  end

  initial
  begin
    {rstn, por_rstn, hsel, hwrite, lo_cmp, warn_cmp, lp_mode} = 7'h0;
    {ret_in, deep_in, wake, rd_dph, err} = 5'h0;
    reg_rdy = 1'b1;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hprot = 4'h3;
    error_cnt = 0;
    samples_checked = 0;
    i = $urandom(45148);
    cyc(12);
    rstn <= 1'b1;
    por_rstn <= 1'b1;
    rd(2'h0, 8'h10);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h04);
    rd(2'h3, 8'h00);
    $display("test reset_values done");
    // bit4 locks on the first write; reserved codes are stored
    wr(2'h0, 8'hed);
    rd(2'h0, 8'h21);
    wr(2'h0, 8'h12);
    rd(2'h0, 8'h02);
    cmp_pin(lo_sel, 2'h2);
    wr(2'h0, 8'h31);
    rd(2'h0, 8'h21);
    cmp_pin(lo_sel, 2'h1);
    $display("test detect_fields done");
    lo_cmp <= 1'b1;
    cyc(6);
    cmp_pin(lo_irq, 1'h1);
    cmp_pin(rst_req, 1'h0);
    rd(2'h0, 8'ha1);
    wr(2'h0, 8'h61);
    rd(2'h0, 8'ha1);
    lo_cmp <= 1'b0;
    cyc(4);
    wr(2'h0, 8'h61);
    rd(2'h0, 8'h21);
    cmp_pin(lo_irq, 1'h0);
    $display("test low_supply done");
    for (i = 0; i < 4; i++)
    begin
      wr(2'h1, {6'h00, i[1:0]});
      cyc(2);
      cmp_pin(warn_sel, i[1:0]);
    end
    rv = 2'($urandom);
    wr(2'h1, {6'h08, rv});
    rd(2'h1, {6'h08, rv});
    warn_cmp <= 1'b1;
    cyc(6);
    cmp_pin(warn_irq, 1'h1);
    rd(2'h1, {6'h28, rv});
    wr(2'h1, {6'h00, rv});
    cyc(2);
    cmp_pin(warn_irq, 1'h0);
    warn_cmp <= 1'b0;
    cyc(4);
    wr(2'h1, {6'h10, rv});
    rd(2'h1, {6'h00, rv});
    $display("test warning done");
    xfer(1'b1, 2'h0, 8'h00, 1'b0);
    cmp_pin(err, 1'h1);
    rd(2'h0, 8'h21);
    lp_mode <= 1'b1;
    lo_cmp <= 1'b1;
    cyc(6);
    cmp_pin(lo_irq, 1'h0);
    rd(2'h0, 8'h21);
    // let the synchroniser drain before detection comes back on
    lo_cmp <= 1'b0;
    cyc(4);
    lp_mode <= 1'b0;
    $display("test refusals done");
    reg_rdy <= 1'b0;
    ret_in <= 1'b1;
    cyc(1);
    ret_in <= 1'b0;
    cyc(1);
    cmp_pin({pad_hold, reg_en, retain}, 3'h5);
    wake <= 1'b1;
    cyc(1);
    wake <= 1'b0;
    cyc(1);
    cmp_pin({pad_hold, reg_en, retain}, 3'h3);
    reg_rdy <= 1'b1;
    cyc(2);
    cmp_pin({pad_hold, reg_en, retain}, 3'h2);
    deep_in <= 1'b1;
    cyc(1);
    deep_in <= 1'b0;
    cyc(1);
    cmp_pin({pad_hold, reg_en, retain}, 3'h4);
    wake <= 1'b1;
    cyc(1);
    wake <= 1'b0;
    cyc(4);
    cmp_pin({pad_hold, reg_en}, 2'h3);
    wr(2'h2, 8'h0c);
    cyc(1);
    cmp_pin(pad_hold, 1'h0);
    rd(2'h2, 8'h04);
    $display("test retention done");
    deep_in <= 1'b1;
    cyc(1);
    deep_in <= 1'b0;
    cyc(2);
    rstn <= 1'b0;
    cyc(2);
    cmp_pin(pad_hold, 1'h0);
    rstn <= 1'b1;
    rd(2'h0, 8'h11);
    cmp_pin(lo_sel, 2'h1);
    lo_cmp <= 1'b1;
    cyc(6);
    cmp_pin(rst_req, 1'h1);
    lo_cmp <= 1'b0;
    cyc(4);
    cmp_pin(rst_req, 1'h1);
    wr(2'h0, 8'h51);
    cyc(2);
    cmp_pin(rst_req, 1'h0);
    $display("test reset_pin done");
    cyc(4);
    complete_run();
  end
endmodule

bind smc_supply_monitor smc_supply_monitor_chk chk (
  .SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .HSEL_I(HSEL_I),
  .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
  .HPROT_I(HPROT_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
  .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
  .LOW_SUPPLY_CMP_I(LOW_SUPPLY_CMP_I), .WAKEUP_I(WAKEUP_I),
  .REG_READY_I(REG_READY_I), .CHIP_RESET_REQ_O(CHIP_RESET_REQ_O),
  .PAD_HOLD_O(PAD_HOLD_O), .REG_ENABLE_O(REG_ENABLE_O),
  .LOGIC_RETAIN_O(LOGIC_RETAIN_O));
